// ==== src/srs_consts.svh ====
// Purpose: Constants for the reset output and soft reset block.
// Assumes: 100 MHz clock, period 10 ns.
// Notes:   Times are in microseconds; cycle counts derive from them.
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH
`define SRS_CLK_PERIOD_NS        10
`define SRS_FILTER_TIME_US       10
`define SRS_EXT_DELAY_US         10000
`define SRS_RED_DELAY_US         2000
`define SRS_FILTER_CYC           ((`SRS_FILTER_TIME_US * 1000 + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)
`define SRS_EXT_DELAY_CYC        ((`SRS_EXT_DELAY_US * 1000 + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)
`define SRS_RED_DELAY_CYC        ((`SRS_RED_DELAY_US * 1000 + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)
`define SRS_CNT_W                20
`define SRS_MODE_SOFT_RESET      2'h3
`define SRS_MODE_WR_NORMAL       2'h0
`define SRS_MODE_WR_SLEEP        2'h1
`define SRS_MODE_WR_STOP         2'h2
`define SRS_UV_THR_RESET         2'h0
`define SRS_SOFT_OUT_RESET       1'h0
`define SRS_DELAY_SEL_RESET      1'h0
`endif

// ==== src/srs_pkg.sv ====
// Purpose: Types for the reset output and soft reset block.
// Assumes: Included constants header defines widths.
// Notes:   Mode state codes differ from the mode field encoding; the controller maps writes.
`include "srs_consts.svh"
package srs_pkg;
    typedef enum logic [2:0] {
        SRS_INIT    = 3'h0,
        SRS_NORMAL  = 3'h1,
        SRS_STOP    = 3'h2,
        SRS_SLEEP   = 3'h3,
        SRS_RESTART = 3'h4,
        SRS_FAILSAFE = 3'h5
    } srs_mode_t;

    typedef struct packed {
        logic       delay_short_sel;
        logic       soft_reset_no_out;
        logic [1:0] uv_threshold_sel;
    } srs_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] mode;
    } srs_mode_wr_t;
endpackage

// ==== src/srs_filter.sv ====
// Purpose: Qualifies the reset cause for the filter time before assertion.
// Assumes: Cause is synchronous to clk_i.
// Notes:   Any drop of the cause restarts the qualification.
`timescale 1ns/1ps
`default_nettype none
`include "srs_consts.svh"
module srs_filter #(
    parameter int unsigned FILTER_CYC = `SRS_FILTER_CYC,
    parameter int unsigned CNT_W      = `SRS_CNT_W
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic cause_i,
    output logic      qualified_o
);
    import srs_pkg::*;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             qual_ff;
    wire              done = (cnt_ff >= CNT_W'(FILTER_CYC - 1));

    assign nxt_cnt = !cause_i ? '0 : (done ? cnt_ff : cnt_ff + CNT_W'(1));

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff  <= '0;
            qual_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            qual_ff <= cause_i && done; // R1
        end
    end
    assign qualified_o = qual_ff;
endmodule
`default_nettype wire

// ==== src/srs_delay.sv ====
// Purpose: Release delay counter for the reset output.
// Assumes: hold_i high while the output must stay low.
// Notes:   The count restarts whenever hold_i returns.
`timescale 1ns/1ps
`default_nettype none
`include "srs_consts.svh"
module srs_delay #(
    parameter int unsigned EXT_CYC = `SRS_EXT_DELAY_CYC,
    parameter int unsigned RED_CYC = `SRS_RED_DELAY_CYC,
    parameter int unsigned CNT_W   = `SRS_CNT_W
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic hold_i,
    input  wire logic short_i,
    output logic      expired_o
);
    import srs_pkg::*;
    logic [CNT_W-1:0] cnt_ff;
    logic             exp_ff;
    wire [CNT_W-1:0]  limit = short_i ? CNT_W'(RED_CYC - 1) : CNT_W'(EXT_CYC - 1); // R3
    wire              reach = (cnt_ff >= limit);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff <= '0;
            exp_ff <= 1'b0;
        end
        else if (hold_i)
        begin
            cnt_ff <= '0; // R12
            exp_ff <= 1'b0;
        end
        else if (!exp_ff)
        begin
            cnt_ff <= reach ? cnt_ff : cnt_ff + CNT_W'(1);
            exp_ff <= reach; // R2
        end
    end
    assign expired_o = exp_ff;
endmodule
`default_nettype wire

// ==== src/srs_reset_ctrl.sv ====
// Function
// R1: Reset output goes low only after a cause persists for the filter time.
// R2: Output stays low while cause persists and until the delay expires.
// R3: Extended delay by default; reduced delay when the short select is set.
// R4: At power-up output held low, released after extended delay once supply good.
// R5: Watchdog failure is a reset cause like undervoltage.
// R6: Undervoltage threshold selectable; defaults to the first falling level.
// R7: Soft reset is requested by writing mode 11, valid in Normal or Stop.
// R8: Soft reset returns to Init and restores all settings to defaults.
// R9: With output option 0, soft reset asserts output with extended delay.
// R10: With output option 1, soft reset leaves output high but still reinitialises.
// R11: Soft reset outside Normal or Stop mode is ignored.
// R12: A new cause during the delay restarts the delay from zero.
//
// Purpose: Drives the active-low reset output and executes soft resets.
// Assumes: Supply comparator and watchdog status arrive synchronous to clk_i.
// Notes:   Mode changes other than soft reset come from the mode_wr port.
`timescale 1ns/1ps
`default_nettype none
`include "srs_consts.svh"
module srs_reset_ctrl #(
    parameter int unsigned FILTER_CYC = `SRS_FILTER_CYC,
    parameter int unsigned EXT_CYC    = `SRS_EXT_DELAY_CYC,
    parameter int unsigned RED_CYC    = `SRS_RED_DELAY_CYC,
    parameter int unsigned CNT_W      = `SRS_CNT_W
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 supply_uv_i,
    input  wire logic                 watchdog_fail_i,
    input  wire srs_pkg::srs_mode_wr_t mode_wr_i,
    input  wire srs_pkg::srs_cfg_t     cfg_wr_i,
    input  wire logic                 cfg_wr_en_i,
    output srs_pkg::srs_cfg_t          cfg_o,
    output srs_pkg::srs_mode_t         mode_o,
    output logic                      soft_reset_o,
    output logic                      reset_out_n
);
    import srs_pkg::*;

    srs_mode_t mode_ff;
    srs_mode_t nxt_mode;
    srs_cfg_t  cfg_ff;
    srs_cfg_t  nxt_cfg;
    logic      soft_ff;
    logic      soft_pulse_ff;
    logic      power_up_ff;
    logic      out_n_ff;
    logic      uv_qual;
    logic      wd_qual;
    logic      expired;

    wire mode_ok   = (mode_ff == SRS_NORMAL) || (mode_ff == SRS_STOP);
    wire soft_req  = mode_wr_i.valid && (mode_wr_i.mode == `SRS_MODE_SOFT_RESET); // R7
    wire soft_take = soft_req && mode_ok; // R11
    wire soft_out  = soft_take && !cfg_ff.soft_reset_no_out; // R9 R10
    wire hold      = uv_qual || wd_qual || soft_pulse_ff || power_up_ff && supply_uv_i;

    // Both causes share one filter path each, so a glitch on either is dropped, except a supply_uv_i glitch during power-up, which holds directly.
    srs_filter #(
        .FILTER_CYC (FILTER_CYC),
        .CNT_W      (CNT_W)
    ) u_uv_filt (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .cause_i     (supply_uv_i),
        .qualified_o (uv_qual)
    );

    srs_filter #(
        .FILTER_CYC (FILTER_CYC),
        .CNT_W      (CNT_W)
    ) u_wd_filt (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .cause_i     (watchdog_fail_i), // R5
        .qualified_o (wd_qual)
    );

    // The soft reset path uses the extended delay regardless of the short select.
    srs_delay #(
        .EXT_CYC (EXT_CYC),
        .RED_CYC (RED_CYC),
        .CNT_W   (CNT_W)
    ) u_delay (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .hold_i    (hold),
        .short_i   (cfg_ff.delay_short_sel && !soft_ff && !power_up_ff), // R3 R9 R4
        .expired_o (expired)
    );

    always_comb
    begin
        nxt_mode = mode_ff;
        if (soft_take)
        begin
            nxt_mode = SRS_INIT; // R8
        end
        else if (mode_wr_i.valid && !soft_req)
        begin
            case (mode_wr_i.mode)
                `SRS_MODE_WR_NORMAL: nxt_mode = SRS_NORMAL;
                `SRS_MODE_WR_SLEEP:  nxt_mode = SRS_SLEEP;
                `SRS_MODE_WR_STOP:   nxt_mode = SRS_STOP;
                default: nxt_mode = mode_ff;
            endcase
        end
    end

    always_comb
    begin
        nxt_cfg = cfg_ff;
        if (soft_take)
        begin
            nxt_cfg.delay_short_sel   = `SRS_DELAY_SEL_RESET; // R8
            nxt_cfg.soft_reset_no_out = `SRS_SOFT_OUT_RESET;
            nxt_cfg.uv_threshold_sel  = `SRS_UV_THR_RESET;
        end
        else if (cfg_wr_en_i)
        begin
            nxt_cfg = cfg_wr_i; // R6
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            mode_ff                  <= SRS_INIT;
            cfg_ff.delay_short_sel   <= `SRS_DELAY_SEL_RESET;
            cfg_ff.soft_reset_no_out <= `SRS_SOFT_OUT_RESET;
            cfg_ff.uv_threshold_sel  <= `SRS_UV_THR_RESET; // R6
            soft_ff                  <= 1'b0;
            soft_pulse_ff            <= 1'b0;
            power_up_ff              <= 1'b1;
            out_n_ff                 <= 1'b0; // R4
        end
        else
        begin
            mode_ff       <= nxt_mode;
            cfg_ff        <= nxt_cfg;
            soft_pulse_ff <= soft_out;
            if (soft_out)
            begin
                soft_ff <= 1'b1;
            end
            // The delay still reads expired in the cycle the pulse starts the hold,
            // so clearing on expired alone would drop the extended-delay force at once.
            else if (expired && !hold)
            begin
                soft_ff <= 1'b0; // R9
            end
            if (expired)
            begin
                power_up_ff <= 1'b0; // R4
            end
            out_n_ff <= expired && !hold; // R1 R2
        end
    end

    assign cfg_o        = cfg_ff;
    assign mode_o       = mode_ff;
    assign soft_reset_o = soft_pulse_ff;
    assign reset_out_n  = out_n_ff;
endmodule
`default_nettype wire

// ==== verif/srs_mcu_model.sv ====
// Purpose: Behavioural controller that issues mode field writes.
// Assumes: Writes launch on the falling edge and last one cycle.
// Notes:   Returns one edge after the write so the answer has landed.
`timescale 1ns/1ps
`default_nettype none
module srs_mcu_model (
    input  wire logic             clk_i,
    output srs_pkg::srs_mode_wr_t mode_wr_o
);
    import srs_pkg::*;
    initial mode_wr_o = '0;
    task automatic send(input logic [1:0] mode);
        @(negedge clk_i);
        mode_wr_o = '{valid: 1'b1, mode: mode};
        @(negedge clk_i);
        mode_wr_o = '0;
        @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// ==== verif/srs_assertions.sv ====
// Purpose: Port checks for the reset output and soft reset block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   The lower release bound counts from the last cause; the upper from the last cause or soft reset.
`timescale 1ns/1ps
`default_nettype none
module srs_chk #(
    parameter int unsigned EXT_CYC = 20,
    parameter int unsigned RED_CYC = 8
) (
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    input wire logic                  supply_uv_i,
    input wire logic                  watchdog_fail_i,
    input wire srs_pkg::srs_mode_wr_t mode_wr_i,
    input wire srs_pkg::srs_cfg_t     cfg_o,
    input wire srs_pkg::srs_mode_t    mode_o,
    input wire logic                  soft_reset_o,
    input wire logic                  reset_out_n
);
    import srs_pkg::*;
    wire logic cause = supply_uv_i | watchdog_fail_i;
    wire logic sr_cmd = mode_wr_i.valid && mode_wr_i.mode == 2'h3;
    int unsigned quiet_ff;
    int unsigned calm_ff;
    always_ff @(posedge clk_i)
    begin
        quiet_ff <= (!rst_n_i || cause) ? 0 : quiet_ff + 1;
        calm_ff  <= (!rst_n_i || cause || soft_reset_o) ? 0 : calm_ff + 1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_take;
        sr_cmd && mode_o inside {SRS_NORMAL, SRS_STOP};
    endsequence
    sequence s_hold_high;
        reset_out_n [*3];
    endsequence
    property p_filter; $rose(cause) && reset_out_n |-> s_hold_high; endproperty
    a_filter: assert property (p_filter) else $error("early reset");
    property p_low; cause [*7] |-> !reset_out_n; endproperty
    a_low: assert property (p_low) else $error("reset missing");
    property p_rel_min;
        $rose(reset_out_n) |-> quiet_ff >= (cfg_o.delay_short_sel ? RED_CYC : EXT_CYC);
    endproperty
    a_rel_min: assert property (p_rel_min) else $error("early release");
    property p_rel_max; calm_ff == EXT_CYC + 8 |-> reset_out_n; endproperty
    a_rel_max: assert property (p_rel_max) else $error("late release");
    property p_init; s_take |=> mode_o == SRS_INIT && cfg_o == '0; endproperty
    a_init: assert property (p_init) else $error("no reinit");
    property p_pulse; s_take ##0 !cfg_o.soft_reset_no_out |=> soft_reset_o ##1 !reset_out_n; endproperty
    a_pulse: assert property (p_pulse) else $error("soft reset output");
    property p_quiet;
        s_take ##0 cfg_o.soft_reset_no_out && reset_out_n |=> !soft_reset_o ##0 s_hold_high;
    endproperty
    a_quiet: assert property (p_quiet) else $error("output pulsed");
    property p_ignore;
        sr_cmd && !(mode_o inside {SRS_NORMAL, SRS_STOP}) |=> $stable(mode_o) && !soft_reset_o;
    endproperty
    a_ignore: assert property (p_ignore) else $error("soft reset taken");
endmodule
bind srs_reset_ctrl srs_chk #(.EXT_CYC(EXT_CYC), .RED_CYC(RED_CYC)) u_chk (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .supply_uv_i(supply_uv_i), .watchdog_fail_i(watchdog_fail_i),
    .mode_wr_i(mode_wr_i), .cfg_o(cfg_o), .mode_o(mode_o), .soft_reset_o(soft_reset_o),
    .reset_out_n(reset_out_n));
`default_nettype wire

// ==== verif/tb_srs_reset_ctrl.sv ====
// Purpose: Self-checking bench for the reset output and soft reset block.
// Assumes: Delays shortened to 20 and 8 cycles, filter to 3.
// Notes:   Release counts are windows, since pipeline depth is the design's choice.
`timescale 1ns/1ps
`default_nettype none
module tb_srs_reset_ctrl;
    import srs_pkg::*;
    localparam int EXT = 20;
    localparam int RED = 8;
    typedef struct packed {logic uv; logic wd; srs_cfg_t cfg; logic [7:0] lo;} srs_row_t;
    srs_row_t     rows [4] = '{'{1, 0, 4'h0, EXT}, '{0, 1, 4'h9, RED},
                               '{1, 1, 4'hA, RED}, '{0, 1, 4'h3, EXT}};
    logic         clk_i = 1'b0, rst_n_i = 1'b0, uv = 1'b1, wd = 1'b0, cfg_en = 1'b0;
    srs_cfg_t     cfg_wr = '0, cfg_q;
    srs_mode_wr_t mode_wr;
    srs_mode_t    mode_q;
    logic         soft_q, out_n;
    int           fail_count = 0, check_count = 0, n;
    srs_reset_ctrl #(.FILTER_CYC(3), .EXT_CYC(EXT), .RED_CYC(RED)) DUT (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .supply_uv_i(uv), .watchdog_fail_i(wd), .mode_wr_i(mode_wr),
        .cfg_wr_i(cfg_wr), .cfg_wr_en_i(cfg_en), .cfg_o(cfg_q), .mode_o(mode_q),
        .soft_reset_o(soft_q), .reset_out_n(out_n));
    srs_mcu_model mcu (.clk_i(clk_i), .mode_wr_o(mode_wr));
    initial forever #5 clk_i = ~clk_i;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic step(input int c);
        repeat (c) @(negedge clk_i);
    endtask
    // The upper bound of the window leaves room for the filter and output stages.
    task automatic wait_rel(input int lo);
        n = 0;
        while (out_n !== 1'b1 && n < 200)
        begin
            step(1);
            n++;
        end
        if (n >= 200)
        begin
            fail_count++;
            wrap_up();
        end
        check({7'h0, n >= lo && n <= lo + 8}, 8'h01);
    endtask
    task automatic cfg(input srs_cfg_t c);
        cfg_wr = c;
        cfg_en = 1'b1;
        step(1);
        cfg_en = 1'b0;
    endtask
    initial
    begin
        step(8);
        check(out_n, 0);
        check(mode_q, SRS_INIT);
        check(cfg_q, 0);
        rst_n_i = 1'b1;
        step(4);
        check(out_n, 0);
        uv = 1'b0;
        wait_rel(EXT);
        foreach (rows[i])
        begin
            cfg(rows[i].cfg);
            check(cfg_q, rows[i].cfg);
            uv = rows[i].uv;
            wd = rows[i].wd;
            step(8);
            check(out_n, 0);
            {uv, wd} = 2'h0;
            wait_rel(rows[i].lo);
        end
        uv = 1'b1;
        step(2);
        uv = 1'b0;
        step(6);
        check(out_n, 1);
        wd = 1'b1;
        step(8);
        wd = 1'b0;
        step(6);
        wd = 1'b1;
        step(4);
        wd = 1'b0;
        wait_rel(EXT);
        mcu.send(2'h0);
        check(mode_q, SRS_NORMAL);
        cfg(4'h9);
        mcu.send(2'h3);
        check(mode_q, SRS_INIT);
        check(cfg_q, 0);
        step(1);
        check(out_n, 0);
        wait_rel(EXT - 4);
        mcu.send(2'h3);
        check(mode_q, SRS_INIT);
        check(out_n, 1);
        mcu.send(2'h0);
        mcu.send(2'h2);
        check(mode_q, SRS_STOP);
        cfg(4'h4);
        mcu.send(2'h3);
        check(mode_q, SRS_INIT);
        step(3);
        check(out_n, 1);
        mcu.send(2'h0);
        mcu.send(2'h1);
        mcu.send(2'h3);
        check(mode_q, SRS_SLEEP);
        wrap_up();
    end
endmodule
`default_nettype wire
